// [image_output_formatter_regs.svh]
// register offsets, field positions, reset values and fixed dimensions of the output formatter
// assumes a 32-bit AHB-Lite register bus and a 10-bit converter sample stream
`ifndef IMAGE_OUTPUT_FORMATTER_REGS_SVH
`define IMAGE_OUTPUT_FORMATTER_REGS_SVH

// register byte offsets
`define CTRL_OFFSET        8'h00
`define BIN_OFFSET         8'h04
`define CROP_START_OFFSET  8'h08
`define CROP_SIZE_OFFSET   8'h0C
`define STATUS_OFFSET      8'h10
`define RANGE_OFFSET       8'h14
`define LIMITS_OFFSET      8'h18

// control register fields
`define CTRL_LAYOUT_LSB    0
`define CTRL_CORE_BIT      4
`define CTRL_REV_COL_BIT   5
`define CTRL_REV_LINE_BIT  6

// layout codes; mosaic codes carry the phase in their two low bits
`define LAYOUT_GRAY_BYTE   4'h0
`define LAYOUT_GRAY_WORD   4'h1
`define LAYOUT_COLOR_TRIO  4'h2
`define LAYOUT_MOSAIC_BYTE 2'h1
`define LAYOUT_MOSAIC_WORD 2'h2

// reset values
`define CTRL_RESET         7'h10
`define BIN_RESET          4'h0

// fixed dimensions and depths
`define SENSOR_COLUMNS     11'h5B0
`define SENSOR_LINES       11'h44A
`define SAMPLE_BITS        10
`define LINE_DEPTH         1456

`endif

// [image_output_formatter_pkg.sv]
// types shared by the output formatter modules
// assumes the constants header is included where codes are needed
package image_output_formatter_pkg;

  // one converter sample with frame and line markers
  typedef struct packed {
    logic [9:0] sample;   // raw converter sample
    logic       sof;      // first pixel of the frame
    logic       eol;      // last pixel of the line
  } pix_in_s;

  // one formatted pixel word to the frame transport
  typedef struct packed {
    logic [23:0] word;    // packed pixel, low bits used by narrow layouts
    logic        sof;
    logic        eol;
  } pix_out_s;

  // software settings
  typedef struct packed {
    logic [3:0] layout;   // output_pixel_layout as selected
    logic       core_en;  // processing core enable
    logic       rev_col;  // column mirror
    logic       rev_line; // line mirror
    logic [1:0] bin_h;    // horizontal binning minus one
    logic [1:0] bin_v;    // vertical binning minus one
    logic [10:0] crop_column_start;
    logic [10:0] crop_line_start;
    logic [10:0] crop_columns;
    logic [10:0] crop_lines;
  } ctrl_s;

  // derived read-only report
  typedef struct packed {
    logic [3:0]  layout;   // reported layout after mirror phase swap
    logic [3:0]  filter;   // 0 none, else mosaic phase plus one
    logic [4:0]  bits_per_pixel_report;
    logic [15:0] darkest_code_value;
    logic [15:0] brightest_code_value;
  } report_s;

  typedef enum logic { FILL, DRAIN } rev_phase_e;

endpackage : image_output_formatter_pkg

// [pixel_word_packer.sv]
// packs a converter sample into the selected layout and derives the layout report
// assumes settings are stable while a frame is moving; purely combinational
`include "image_output_formatter_regs.svh"
`timescale 1ns/1ps
module pixel_word_packer (
  input  wire logic [9:0]                          sample,
  input  wire image_output_formatter_pkg::ctrl_s   ctrl,
  output logic      [23:0]                         word,
  output image_output_formatter_pkg::report_s      report
);

  logic [1:0] phase;  // mosaic phase after mirror swaps
  logic       mosaic; // a mosaic layout is selected

  // pixel packing
  always_comb begin
    word = 24'h000000;
    if (ctrl.layout == `LAYOUT_GRAY_WORD || ctrl.layout[3:2] == `LAYOUT_MOSAIC_WORD) begin
      if (ctrl.core_en) begin
        word[15:0] = {sample, sample[9:4]};
      end else begin
        word[9:0] = sample;
      end
    end else if (ctrl.layout == `LAYOUT_COLOR_TRIO) begin
      word = {3{sample[9:2]}};               // gray replicated into three components
    end else begin
      word[7:0] = sample[9:2];               // byte layouts drop the low bits
    end
  end

  // layout report
  always_comb begin
    mosaic = (ctrl.layout[3:2] == `LAYOUT_MOSAIC_BYTE) ||
             (ctrl.layout[3:2] == `LAYOUT_MOSAIC_WORD);
    phase  = ctrl.layout[1:0] ^ {ctrl.rev_line, ctrl.rev_col};
    report.layout = mosaic ? {ctrl.layout[3:2], phase} : ctrl.layout;
    report.filter = mosaic ? {2'h0, phase} + 4'h1 : 4'h0;
    report.darkest_code_value = 16'h0000;
    if (ctrl.layout == `LAYOUT_GRAY_WORD || ctrl.layout[3:2] == `LAYOUT_MOSAIC_WORD) begin
      report.bits_per_pixel_report = 5'h10;
      report.brightest_code_value  = ctrl.core_en ? 16'hFFFF : 16'h03FF;
    end else if (ctrl.layout == `LAYOUT_COLOR_TRIO) begin
      report.bits_per_pixel_report = 5'h18;
      report.brightest_code_value  = 16'h00FF;                  // per colour component
    end else begin
      report.bits_per_pixel_report = 5'h08;
      report.brightest_code_value  = 16'h00FF;
    end
  end

endmodule : pixel_word_packer

// [line_reverser.sv]
// one-line buffer that replays each line forward or column-mirrored
// assumes upstream honours in_ready; a line never exceeds the buffer depth
`include "image_output_formatter_regs.svh"
`timescale 1ns/1ps
module line_reverser (
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                rev_col,
  input  wire image_output_formatter_pkg::pix_in_s in_pix,
  input  wire logic                                in_valid,
  output logic                                     in_ready,
  output image_output_formatter_pkg::pix_in_s      out_pix,
  output logic                                     out_valid,
  input  wire logic                                out_ready
);

  typedef struct packed {
    image_output_formatter_pkg::rev_phase_e phase;
    logic [10:0] wr_idx;     // next write slot
    logic [10:0] rd_idx;     // next read slot
    logic [10:0] last_idx;   // slot of the line's last pixel
    logic [10:0] left;       // pixels still to replay minus one
    logic        line_sof;   // line opened the frame
    logic        first;      // next replayed pixel opens the line
    logic        out_valid;
    image_output_formatter_pkg::pix_in_s out;
  } state_s;

  state_s     s_q;
  state_s     s_d;
  logic [9:0] mem [0:`LINE_DEPTH-1];  // line storage
  logic       wr_en;

  assign in_ready  = (s_q.phase == image_output_formatter_pkg::FILL);
  assign wr_en     = in_ready && in_valid;
  assign out_pix   = s_q.out;
  assign out_valid = s_q.out_valid;

  // line storage write
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[s_q.wr_idx] <= in_pix.sample;
    end
  end

  // fill and replay sequencing
  always_comb begin
    s_d = s_q;
    if (out_ready) begin
      s_d.out_valid = 1'b0;  // word taken downstream
    end
    case (s_q.phase)
      image_output_formatter_pkg::FILL: begin
        if (wr_en) begin
          if (s_q.wr_idx == 11'h000) begin
            s_d.line_sof = in_pix.sof;
          end
          s_d.wr_idx = s_q.wr_idx + 11'h001;
          if (in_pix.eol) begin
            s_d.phase    = image_output_formatter_pkg::DRAIN;
            s_d.last_idx = s_q.wr_idx;
            s_d.left     = s_q.wr_idx;
            s_d.rd_idx   = rev_col ? s_q.wr_idx : 11'h000;
            s_d.wr_idx   = 11'h000;
            s_d.first    = 1'b1;
          end
        end
      end
      image_output_formatter_pkg::DRAIN: begin
        if (!s_q.out_valid || out_ready) begin
          s_d.out_valid  = 1'b1;
          s_d.out.sample = mem[s_q.rd_idx];
          s_d.out.sof    = s_q.first && s_q.line_sof;
          s_d.out.eol    = (s_q.left == 11'h000);
          s_d.first      = 1'b0;
          s_d.rd_idx     = rev_col ? s_q.rd_idx - 11'h001 : s_q.rd_idx + 11'h001;
          s_d.left       = s_q.left - 11'h001;
          if (s_q.left == 11'h000) begin
            s_d.phase = image_output_formatter_pkg::FILL;
          end
        end
      end
      default: begin
        s_d.phase = image_output_formatter_pkg::FILL;
      end
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : line_reverser

// [image_output_formatter.sv]
// output formatter: AHB-Lite registers, column mirror, crop and pixel packing
// assumes sensor samples arrive on hclk; the sensor reads lines bottom-up on request
`include "image_output_formatter_regs.svh"
`timescale 1ns/1ps
module image_output_formatter (
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [7:0]                           haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic      [31:0]                          hrdata,
  output logic                                      hresp,
  input  wire logic                                 color_part_pin,
  input  wire image_output_formatter_pkg::pix_in_s  in_pix,
  input  wire logic                                 in_valid,
  output logic                                      in_ready,
  output image_output_formatter_pkg::pix_out_s      out_pix,
  output logic                                      out_valid,
  input  wire logic                                 out_ready,
  output logic                                      read_lines_reversed,
  output logic                                      auto_algo_enable
);

  typedef struct packed {
    image_output_formatter_pkg::ctrl_s ctrl;
    logic        wr_pend;     // write data phase pending
    logic [7:0]  wr_addr;     // address of pending write
    logic [31:0] rdata;       // read data for the data phase
    logic        strap_meta;  // strap first stage
    logic        strap;       // strap second stage
    logic [10:0] col;         // column of next pixel after mirror
    logic [10:0] line;        // line of next pixel after mirror
    logic        fmt_valid;
    image_output_formatter_pkg::pix_out_s fmt;
  } state_s;

  state_s                                s_q;
  state_s                                s_d;
  image_output_formatter_pkg::pix_in_s   rev_pix;     // mirrored stream
  logic                                  rev_valid;
  logic                                  rev_ready;
  logic [23:0]                           packed_word; // formatted sample
  image_output_formatter_pkg::report_s   report;      // derived values
  image_output_formatter_pkg::ctrl_s     ctrl_new;    // candidate control write
  logic                                  addr_take;   // valid address phase
  logic [10:0]                           widest_frame_limit;
  logic [10:0]                           tallest_frame_limit;
  logic                                  in_col;      // pixel inside crop columns
  logic                                  in_line;     // pixel inside crop lines
  logic                                  legal;       // candidate layout allowed
  logic [11:0]                           col_end;
  logic [11:0]                           line_end;

  // column mirror buffer
  line_reverser u_line_reverser (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .rev_col   (s_q.ctrl.rev_col),
    .in_pix    (in_pix),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_pix   (rev_pix),
    .out_valid (rev_valid),
    .out_ready (rev_ready)
  );

  // sample packing and layout report
  pixel_word_packer u_pixel_word_packer (
    .sample (rev_pix.sample),
    .ctrl   (s_q.ctrl),
    .word   (packed_word),
    .report (report)
  );

  assign hreadyout           = 1'b1;                 // zero wait states
  assign hresp               = 1'b0;                 // always OKAY
  assign hrdata              = s_q.rdata;
  assign out_pix             = s_q.fmt;
  assign out_valid           = s_q.fmt_valid;
  assign rev_ready           = !s_q.fmt_valid || out_ready;
  assign read_lines_reversed = s_q.ctrl.rev_line;
  assign auto_algo_enable    = s_q.ctrl.core_en;
  assign addr_take           = hsel && hready && htrans[1];

  // frame limits after binning, independent of crop
  always_comb begin
    case (s_q.ctrl.bin_h)
      2'h0:    widest_frame_limit = `SENSOR_COLUMNS;
      2'h1:    widest_frame_limit = `SENSOR_COLUMNS / 11'd2;
      2'h2:    widest_frame_limit = `SENSOR_COLUMNS / 11'd3;
      default: widest_frame_limit = `SENSOR_COLUMNS / 11'd4;
    endcase
    case (s_q.ctrl.bin_v)
      2'h0:    tallest_frame_limit = `SENSOR_LINES;
      2'h1:    tallest_frame_limit = `SENSOR_LINES / 11'd2;
      2'h2:    tallest_frame_limit = `SENSOR_LINES / 11'd3;
      default: tallest_frame_limit = `SENSOR_LINES / 11'd4;
    endcase
  end

  // candidate control value and its legality
  always_comb begin
    ctrl_new          = s_q.ctrl;
    ctrl_new.layout   = hwdata[`CTRL_LAYOUT_LSB +: 4];
    ctrl_new.core_en  = hwdata[`CTRL_CORE_BIT];
    ctrl_new.rev_col  = hwdata[`CTRL_REV_COL_BIT];
    ctrl_new.rev_line = hwdata[`CTRL_REV_LINE_BIT];
    if (ctrl_new.layout[3:2] == `LAYOUT_MOSAIC_BYTE ||
        ctrl_new.layout[3:2] == `LAYOUT_MOSAIC_WORD) begin
      legal = s_q.strap && !ctrl_new.core_en;
    end else if (ctrl_new.layout == `LAYOUT_COLOR_TRIO) begin
      legal = s_q.strap && ctrl_new.core_en;
    end else if (ctrl_new.layout == `LAYOUT_GRAY_BYTE ||
                 ctrl_new.layout == `LAYOUT_GRAY_WORD) begin
      legal = !s_q.strap || ctrl_new.core_en;
    end else begin
      legal = 1'b0;                                               // unknown code
    end
  end

  // crop window after mirroring
  always_comb begin
    col_end  = {1'b0, s_q.ctrl.crop_column_start} + {1'b0, s_q.ctrl.crop_columns};
    line_end = {1'b0, s_q.ctrl.crop_line_start} + {1'b0, s_q.ctrl.crop_lines};
    in_col   = ({1'b0, s_q.col} < col_end) && (s_q.col >= s_q.ctrl.crop_column_start);
    in_line  = ({1'b0, s_q.line} < line_end) && (s_q.line >= s_q.ctrl.crop_line_start);
  end

  // next-state logic
  always_comb begin
    s_d            = s_q;
    s_d.strap_meta = color_part_pin;
    s_d.strap      = s_q.strap_meta;
    // register write data phase
    s_d.wr_pend    = addr_take && hwrite;
    s_d.wr_addr    = haddr;
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        `CTRL_OFFSET: begin
          if (legal) begin
            s_d.ctrl = ctrl_new;                                  // refused whole if illegal
          end
        end
        `BIN_OFFSET: begin
          s_d.ctrl.bin_h = hwdata[1:0];
          s_d.ctrl.bin_v = hwdata[3:2];
        end
        `CROP_START_OFFSET: begin
          s_d.ctrl.crop_column_start = hwdata[10:0];
          s_d.ctrl.crop_line_start   = hwdata[26:16];
        end
        `CROP_SIZE_OFFSET: begin
          s_d.ctrl.crop_columns = hwdata[10:0];
          s_d.ctrl.crop_lines   = hwdata[26:16];
        end
        default: begin
          s_d.ctrl = s_q.ctrl;                                    // read-only or unmapped
        end
      endcase
    end
    // register read, sampled in the address phase
    if (addr_take && !hwrite) begin
      case (haddr)
        `CTRL_OFFSET:       s_d.rdata = {25'h0, s_q.ctrl.rev_line, s_q.ctrl.rev_col,
                                         s_q.ctrl.core_en, s_q.ctrl.layout};
        `BIN_OFFSET:        s_d.rdata = {28'h0, s_q.ctrl.bin_v, s_q.ctrl.bin_h};
        `CROP_START_OFFSET: s_d.rdata = {5'h0, s_q.ctrl.crop_line_start,
                                         5'h0, s_q.ctrl.crop_column_start};
        `CROP_SIZE_OFFSET:  s_d.rdata = {5'h0, s_q.ctrl.crop_lines,
                                         5'h0, s_q.ctrl.crop_columns};
        `STATUS_OFFSET:     s_d.rdata = {14'h0, s_q.ctrl.core_en, s_q.strap, 3'h0,
                                         report.bits_per_pixel_report,
                                         report.filter, report.layout};
        `RANGE_OFFSET:      s_d.rdata = {report.brightest_code_value,
                                         report.darkest_code_value};
        `LIMITS_OFFSET:     s_d.rdata = {5'h0, tallest_frame_limit,
                                         5'h0, widest_frame_limit};
        default:            s_d.rdata = 32'h00000000;
      endcase
    end
    // output stage: crop then pack
    if (out_ready) begin
      s_d.fmt_valid = 1'b0;
    end
    if (rev_valid && rev_ready) begin
      if (rev_pix.sof) begin
        s_d.line = 11'h000;
      end
      if (in_col && (in_line || rev_pix.sof) &&
          (!rev_pix.sof || s_q.ctrl.crop_line_start == 11'h000)) begin
        s_d.fmt_valid = 1'b1;
        s_d.fmt.word  = packed_word;
        s_d.fmt.sof   = (s_q.col == s_q.ctrl.crop_column_start) &&
                        ((rev_pix.sof ? 11'h000 : s_q.line) == s_q.ctrl.crop_line_start);
        s_d.fmt.eol   = ({1'b0, s_q.col} == col_end - 12'h001) || rev_pix.eol;
      end
      if (rev_pix.eol) begin
        s_d.col  = 11'h000;
        s_d.line = (rev_pix.sof ? 11'h000 : s_q.line) + 11'h001;
      end else begin
        s_d.col  = s_q.col + 11'h001;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q                        <= '0;
      s_q.ctrl.layout            <= 4'(`CTRL_RESET & 7'h0F);
      s_q.ctrl.core_en           <= 1'b1;
      s_q.ctrl.crop_columns      <= `SENSOR_COLUMNS;
      s_q.ctrl.crop_lines        <= `SENSOR_LINES;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : image_output_formatter

// [formatter_monitor.sv]
// checker watching the output formatter ports
// assumes it is bound to image_output_formatter and shares its hclk domain
`include "image_output_formatter_regs.svh"
`timescale 1ns/1ps
module formatter_monitor (
  input wire logic                                 hclk,
  input wire logic                                 hresetn,
  input wire logic                                 hsel,
  input wire logic [7:0]                           haddr,
  input wire logic [1:0]                           htrans,
  input wire logic                                 hwrite,
  input wire logic [31:0]                          hwdata,
  input wire logic                                 hready,
  input wire logic                                 hreadyout,
  input wire logic                                 hresp,
  input wire logic                                 color_part_pin,
  input wire image_output_formatter_pkg::pix_in_s  in_pix,
  input wire logic                                 in_valid,
  input wire logic                                 in_ready,
  input wire image_output_formatter_pkg::pix_out_s out_pix,
  input wire logic                                 out_valid,
  input wire logic                                 out_ready,
  input wire logic                                 read_lines_reversed,
  input wire logic                                 auto_algo_enable
);
  logic wr_ctrl_q; // control write is in its data phase
  // track the data phase of a control register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_q <= 1'b0;
    end else begin
      wr_ctrl_q <= hsel && hready && htrans[1] && hwrite && haddr == `CTRL_OFFSET;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout)
    else $error("wait state inserted");
  okay_resp_a: assert property (!hresp)
    else $error("error response seen");
  reset_idle_a: assert property ($rose(hresetn) |-> in_ready && !out_valid)
    else $error("stream busy after reset");
  stall_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
    else $error("output changed while stalled");
  fill_stop_a: assert property (in_valid && in_ready && in_pix.eol |=> !in_ready)
    else $error("input taken during replay");
  raw_upper_a: assert property (out_valid && !auto_algo_enable |-> !(|out_pix.word[23:10]))
    else $error("raw word upper bits not zero");
  ctrl_follow_a: assert property (wr_ctrl_q && !color_part_pin && hwdata[3:1] == 3'h0
    |=> auto_algo_enable == $past(hwdata[4]) && read_lines_reversed == $past(hwdata[6]))
    else $error("control outputs do not follow write");
  mosaic_refuse_a: assert property (wr_ctrl_q && color_part_pin && hwdata[3] && hwdata[4]
    |=> $stable(auto_algo_enable))
    else $error("mosaic with core accepted");
  cover property (out_valid && !out_ready);
  cover property (wr_ctrl_q && color_part_pin);
  cover property (in_valid && in_ready && in_pix.eol);
endmodule : formatter_monitor

bind image_output_formatter formatter_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .color_part_pin(color_part_pin),
  .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .out_pix(out_pix),
  .out_valid(out_valid), .out_ready(out_ready), .read_lines_reversed(read_lines_reversed),
  .auto_algo_enable(auto_algo_enable));

// [frame_sink.sv]
// frame transport model: takes formatted pixels, optionally stalling
// assumes the formatter holds out_pix and out_valid until taken
`timescale 1ns/1ps
module frame_sink (
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 stall,
  input  wire image_output_formatter_pkg::pix_out_s out_pix,
  input  wire logic                                 out_valid,
  output logic                                      out_ready
);
  image_output_formatter_pkg::pix_out_s got[$]; // accepted pixels in order
  // take a pixel at each ready edge; a stall toggles ready every cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        got.push_back(out_pix);
      end
      out_ready <= stall ? !out_ready : 1'b1;
    end
  end
endmodule : frame_sink

// [tb.sv]
// testbench: register reads and writes plus one-line frames through the formatter
// assumes a single AHB-Lite slave and the frame_sink model downstream
`include "image_output_formatter_regs.svh"
`timescale 1ns/1ps
module tb;
  logic        hclk, hresetn, hsel, hwrite, color_part_pin, in_valid, stall;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        hreadyout, hresp, in_ready, out_valid, out_ready, rlr, aae;
  image_output_formatter_pkg::pix_in_s  in_pix;
  image_output_formatter_pkg::pix_out_s out_pix;
  int          bad_count, checks_done, base;
  image_output_formatter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .color_part_pin(color_part_pin),
    .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .out_pix(out_pix),
    .out_valid(out_valid), .out_ready(out_ready), .read_lines_reversed(rlr),
    .auto_algo_enable(aae));
  frame_sink u_sink (.hclk(hclk), .hresetn(hresetn), .stall(stall), .out_pix(out_pix),
    .out_valid(out_valid), .out_ready(out_ready));
  // free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // print the counts and the verdict, then stop
  task results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // compare one value against its expectation
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // wait for bus or stream ready, sampled settled before the edge
  task wait_ok(input bit strm);
    int   k;
    logic ok;
    k = 0;
    do begin
      @(negedge hclk);
      ok = strm ? in_ready : hreadyout;
      rd = hrdata;
      @(posedge hclk);
      k++;
      if (k > 3000) begin
        bad_count++;
        results();
      end
    end while (ok !== 1'b1);
  endtask : wait_ok
  // single AHB-Lite word transfer: address phase, then data phase
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ok(0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    wait_ok(0);
  endtask : bus
  // read a register and compare
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // one-line frame of n samples; expect m cropped words from column c0
  task line(input int n, input int m, input int c0, input bit rev, input int mode);
    logic [9:0] s;
    int         k;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_pix <= '{sample: 10'h3C0 + 10'(i), sof: i == 0, eol: i == n - 1};
      wait_ok(1);
    end
    in_valid <= 1'b0;
    k = 0;
    while (u_sink.got.size() < base + m && k < 500) begin
      @(posedge hclk);
      k++;
    end
    // a line that never drains counts as a mismatch and ends the run
    if (u_sink.got.size() < base + m) begin
      bad_count++;
      results();
    end
    chk({31'h0, u_sink.got[base].sof}, 32'h1);
    for (int j = 0; j < m; j++) begin
      s = 10'h3C0 + 10'(rev ? n - 1 - c0 - j : c0 + j);
      chk({8'h0, u_sink.got[base + j].word}, mode == 0 ? {22'h0, s} :
        mode == 1 ? {16'h0, s, s[9:4]} : {24'h0, s[9:2]});
    end
    chk({31'h0, u_sink.got[base + m - 1].eol}, 32'h1);
    base = base + m;
  endtask : line
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    color_part_pin = 1'b0;
    in_valid = 1'b0;
    in_pix = '0;
    stall = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`CTRL_OFFSET, 32'h10);
    rdc(`STATUS_OFFSET, 32'h0002_0800);
    rdc(`RANGE_OFFSET, 32'h00FF_0000);
    rdc(`CROP_SIZE_OFFSET, 32'h044A_05B0);
    rdc(8'h1C, 32'h0);
    bus(`BIN_OFFSET, 1'b1, 32'hB);
    bus(`CROP_SIZE_OFFSET, 1'b1, 32'h0001_0004);
    rdc(`LIMITS_OFFSET, 32'h016E_016C);
    bus(`CTRL_OFFSET, 1'b1, 32'h01);
    rdc(`RANGE_OFFSET, 32'h03FF_0000);
    chk({31'h0, aae}, 32'h0);
    line(4, 4, 0, 1'b0, 0);
    bus(`CTRL_OFFSET, 1'b1, 32'h21);
    bus(`CROP_START_OFFSET, 1'b1, 32'h1);
    bus(`CROP_SIZE_OFFSET, 1'b1, 32'h0001_0002);
    stall <= 1'b1;
    line(4, 2, 1, 1'b1, 0);
    stall <= 1'b0;
    bus(`CTRL_OFFSET, 1'b1, 32'h11);
    rdc(`RANGE_OFFSET, 32'hFFFF_0000);
    line(4, 2, 1, 1'b0, 1);
    bus(`CTRL_OFFSET, 1'b1, 32'h10);
    line(4, 2, 1, 1'b0, 2);
    bus(`CTRL_OFFSET, 1'b1, 32'h08);
    rdc(`CTRL_OFFSET, 32'h10);
    color_part_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    // mosaic word without core, every mirror combination
    for (int m = 0; m < 4; m++) begin
      bus(`CTRL_OFFSET, 1'b1, {25'h0, 2'(m), 5'h08});
      rdc(`STATUS_OFFSET, 32'h0001_1000 + 32'((m + 1) * 16 + 8 + m));
      chk({31'h0, rlr}, 32'(m / 2));
    end
    bus(`CTRL_OFFSET, 1'b1, 32'h18);
    rdc(`CTRL_OFFSET, 32'h68);
    bus(`CTRL_OFFSET, 1'b1, 32'h12);
    rdc(`STATUS_OFFSET, 32'h0003_1802);
    results();
  end
endmodule : tb
